// ===== src/rxc_regs.vh
`ifndef RXC_REGS_VH
`define RXC_REGS_VH

// ------------------------------------------------------------
// register offsets, bank 1
// ------------------------------------------------------------
`define RXC_OFS_STATUS 8'h4A
`define RXC_OFS_ENABLE 8'h4B
`define RXC_OFS_DATE_ALARM 8'h49
`define RXC_OFS_STACK_LO 8'h4E
`define RXC_OFS_STACK_HI 8'h4F
`define RXC_BANK_BASE 8'h40

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define RXC_ST_AUX_VALID 7
`define RXC_ST_UIP 6
`define RXC_ST_RSV_HI 5
`define RXC_ST_RSV_LO 4
`define RXC_ST_PWR_INACT 3
`define RXC_ST_RCF 2
`define RXC_ST_WKF 1
`define RXC_ST_KSF 0

// ------------------------------------------------------------
// enable register fields
// ------------------------------------------------------------
`define RXC_EN_AUX_BAT 7
`define RXC_EN_OSC_OUT 6
`define RXC_EN_XTAL_SEL 5
`define RXC_EN_RAM_CLEAR_INPUT_N 4
`define RXC_EN_PF_SEL 3
`define RXC_EN_RC_IRQ 2
`define RXC_EN_WK_IRQ 1
`define RXC_EN_KS_IRQ 0

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define RXC_RST_STATUS 8'h08
`define RXC_RST_ENABLE 8'h00
`define RXC_USER_RAM_BYTES 242
`define RXC_USER_RAM_BASE 8'h0E
`define RXC_CLK_HZ 10000000
`define RXC_UIP_LEAD_MS 122
`define RXC_UIP_LEAD_CYC ((`RXC_CLK_HZ / 1000) * `RXC_UIP_LEAD_MS)
`define RXC_REC_NS 20000
`define RXC_REC_CYC ((`RXC_REC_NS + 99) / 100)
`define RXC_KSPW_NS 1000
`define RXC_KSPW_CYC ((`RXC_KSPW_NS + 99) / 100)

`endif

// ===== src/rxc_addr_stack.v
`timescale 1ns/1ps
// ------------------------------------------------------------
// four-deep stack of latched bus addresses
// ------------------------------------------------------------
module rxc_addr_stack #(
  parameter WIDTH = 8
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire push_i,
  input wire [WIDTH-1:0] addr_i,
  output wire [WIDTH-1:0] cur_o,
  output wire [WIDTH-1:0] prev1_o,
  output wire [WIDTH-1:0] prev2_o,
  output wire [WIDTH-1:0] prev3_o
);
  reg [WIDTH-1:0] slot0_ff;
  reg [WIDTH-1:0] slot1_ff;
  reg [WIDTH-1:0] slot2_ff;
  reg [WIDTH-1:0] slot3_ff;

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot0_ff <= {WIDTH{1'b0}};
      slot1_ff <= {WIDTH{1'b0}};
      slot2_ff <= {WIDTH{1'b0}};
      slot3_ff <= {WIDTH{1'b0}};
    end else if (push_i) begin
      slot0_ff <= addr_i;
      slot1_ff <= slot0_ff;
      slot2_ff <= slot1_ff;
      slot3_ff <= slot2_ff;
    end
  end

  assign cur_o = slot0_ff;
  assign prev1_o = slot1_ff;
  assign prev2_o = slot2_ff;
  assign prev3_o = slot3_ff;
endmodule // rxc_addr_stack

// ===== src/rxc_ext_ctrl.v
`timescale 1ns/1ps
`include "rxc_regs.vh"
//
// Contract
// - enabled clear falling edge: user ram all ones
// - clear touches only user ram bytes
// - set ram clear flag when done
// - supply present and enabled: irq low
// - writing zero flag releases irq
// - host accesses ignored during recovery time
// - clear disabled: no ram or flag effect
// - extended registers at 4a and 4b
// - bit 7 reads aux battery present
// - update flag 122 ms before update
// - power bit drives open-drain power output
// - enabled wake or kick clears power bit
// - flags: write zero clears, one sets
// - alarm match sets wake-up flag
// - kickstart low pulse sets kickstart flag
// - aux battery enable bit gates use
// - osc enable drives oscillator to output
// - crystal select picks load capacitance
// - power fail: select keeps or floats power
// - wake-up enable drives power and irq
// - kickstart enable acts the same way
// - strobe fall pushes address; 4e/4f read
// - kickstart needs minimum low pulse width
// - wake-up is date and time alarm match
//
module rxc_ext_ctrl #(
  parameter UIP_LEAD_CYC = `RXC_UIP_LEAD_CYC,
  parameter REC_CYC = `RXC_REC_CYC,
  parameter KSPW_CYC = `RXC_KSPW_CYC,
  parameter RAM_BYTES = `RXC_USER_RAM_BYTES
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire [7:0] ad_i,
  output reg [7:0] ad_o,
  output reg ad_oe_o,
  input wire ale_i,
  input wire cs_n_i,
  input wire rd_n_i,
  input wire wr_n_i,
  input wire bank_select_bit_i,
  input wire vcc_ok_i,
  input wire aux_battery_valid_i,
  input wire update_start_i,
  input wire update_end_i,
  input wire osc_clk_i,
  input wire osc_run_i,
  input wire [7:0] time_sec_i,
  input wire [7:0] time_min_i,
  input wire [7:0] time_hour_i,
  input wire [7:0] time_date_i,
  input wire [7:0] alarm_sec_i,
  input wire [7:0] alarm_min_i,
  input wire [7:0] alarm_hour_i,
  input wire ram_clear_input_n_i,
  input wire kickstart_input_n_i,
  output reg irq_n_o,
  output reg power_on_output_n_o,
  output reg power_on_oe_o,
  output reg square_wave_output_o,
  output reg xtal_12p5_sel_o,
  output reg aux_battery_en_o,
  output reg clear_busy_o
);
  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_CLEAR = 2'd1;
  localparam ST_DONE = 2'd2;

  reg [7:0] status_ff;
  reg [7:0] enable_ff;
  reg [7:0] date_alarm_ff;
  reg [7:0] user_ram [0:RAM_BYTES-1];
  reg [7:0] addr_ff;
  reg ale_d_ff;
  reg rd_d_ff;
  reg wr_d_ff;
  reg ram_clear_input_n_d_ff;
  reg ks_d_ff;
  reg match_d_ff;
  reg [1:0] state_ff;
  reg [7:0] clr_idx_ff;
  reg [15:0] rec_cnt_ff;
  reg [15:0] ks_cnt_ff;
  reg ks_armed_ff;
  reg [31:0] uip_cnt_ff;
  reg uip_wait_ff;
  reg uip_ff;
  reg vcc_d_ff;
  reg pwr_hold_ff;
  reg [7:0] nxt_status;

  wire stk_push;
  wire [7:0] stk_cur;
  wire [7:0] stk_p1;
  wire [7:0] stk_p2;
  wire [7:0] stk_p3;
  wire locked;
  wire host_wr;
  wire host_rd;
  wire ram_clear_input_n_fall;
  wire ks_event;
  wire alarm_match;
  wire wake_event;
  wire in_bank1;
  wire ram_sel;
  wire [7:0] ram_idx;
  wire wk_pend;
  wire ks_pend;
  wire rc_pend;

  // ----------------------------------------------------------
  // address strobe and stack
  // ----------------------------------------------------------
  assign stk_push = ale_d_ff & ~ale_i;

  rxc_addr_stack #(
    .WIDTH(8)
  ) u_stack (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .push_i(stk_push),
    .addr_i(ad_i),
    .cur_o(stk_cur),
    .prev1_o(stk_p1),
    .prev2_o(stk_p2),
    .prev3_o(stk_p3)
  );

  // ----------------------------------------------------------
  // decode and edges
  // ----------------------------------------------------------
  assign locked = (rec_cnt_ff != 16'h0000);
  assign host_wr = ~cs_n_i & wr_d_ff & wr_n_i & ~locked;
  assign host_rd = ~cs_n_i & ~rd_n_i & ~locked;
  assign in_bank1 = bank_select_bit_i;
  assign ram_idx = addr_ff - `RXC_USER_RAM_BASE;
  assign ram_sel = (addr_ff >= `RXC_USER_RAM_BASE) &&
    (addr_ff < 8'h40) && !in_bank1;
  assign ram_clear_input_n_fall = ram_clear_input_n_d_ff & ~ram_clear_input_n_i;
  assign alarm_match = (time_date_i == date_alarm_ff) &&
    (time_hour_i == alarm_hour_i) && (time_min_i == alarm_min_i) &&
    (time_sec_i == alarm_sec_i);
  assign wake_event = alarm_match & ~match_d_ff;
  assign ks_event = ks_armed_ff & kickstart_input_n_i & ~ks_d_ff;
  assign wk_pend = status_ff[`RXC_ST_WKF] & enable_ff[`RXC_EN_WK_IRQ];
  assign ks_pend = status_ff[`RXC_ST_KSF] & enable_ff[`RXC_EN_KS_IRQ];
  assign rc_pend = status_ff[`RXC_ST_RCF] & enable_ff[`RXC_EN_RC_IRQ];

  // ----------------------------------------------------------
  // bus sampling, latched address
  // ----------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ale_d_ff <= 1'b0;
      rd_d_ff <= 1'b1;
      wr_d_ff <= 1'b1;
      ram_clear_input_n_d_ff <= 1'b1;
      ks_d_ff <= 1'b1;
      match_d_ff <= 1'b0;
      vcc_d_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      ale_d_ff <= ale_i;
      rd_d_ff <= rd_n_i;
      wr_d_ff <= ~wr_n_i;
      ram_clear_input_n_d_ff <= ram_clear_input_n_i;
      ks_d_ff <= kickstart_input_n_i;
      match_d_ff <= alarm_match;
      vcc_d_ff <= vcc_ok_i;
      if (stk_push) begin
        addr_ff <= ad_i;
      end
    end
  end

  // ----------------------------------------------------------
  // kickstart pulse width qualifier
  // ----------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ks_cnt_ff <= 16'h0000;
      ks_armed_ff <= 1'b0;
    end else if (kickstart_input_n_i) begin
      ks_cnt_ff <= 16'h0000;
      ks_armed_ff <= 1'b0;
    end else if (ks_cnt_ff >= KSPW_CYC[15:0] - 16'h0001) begin
      ks_armed_ff <= 1'b1;
    end else begin
      ks_cnt_ff <= ks_cnt_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------
  // update-in-progress timing
  // ----------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      uip_cnt_ff <= 32'h0000_0000;
      uip_wait_ff <= 1'b0;
      uip_ff <= 1'b0;
    end else if (update_end_i) begin
      uip_ff <= 1'b0;
      uip_wait_ff <= 1'b0;
    end else if (update_start_i) begin
      uip_wait_ff <= 1'b1;
      uip_cnt_ff <= 32'h0000_0000;
    end else if (uip_wait_ff && !uip_ff) begin
      uip_cnt_ff <= uip_cnt_ff + 32'h0000_0001;
      if (uip_cnt_ff >= UIP_LEAD_CYC - 1) begin
        uip_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------
  // ram clear sequencer and recovery lockout
  // ----------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
      clr_idx_ff <= 8'h00;
      rec_cnt_ff <= 16'h0000;
    end else begin
      if (ram_clear_input_n_fall) begin
        rec_cnt_ff <= REC_CYC[15:0];
      end else if (locked) begin
        rec_cnt_ff <= rec_cnt_ff - 16'h0001;
      end
      case (state_ff)
        ST_IDLE: begin
          if (ram_clear_input_n_fall && enable_ff[`RXC_EN_RAM_CLEAR_INPUT_N]) begin
            state_ff <= ST_CLEAR;
            clr_idx_ff <= 8'h00;
          end
        end
        ST_CLEAR: begin
          if (clr_idx_ff == RAM_BYTES - 1) begin
            state_ff <= ST_DONE;
          end else begin
            clr_idx_ff <= clr_idx_ff + 8'h01;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // only user ram is touched; calendar and extended ram are elsewhere
  always @(posedge ref_clk_i) begin
    if (state_ff == ST_CLEAR) begin
      user_ram[clr_idx_ff] <= 8'hFF;
    end else if (host_wr && ram_sel) begin
      user_ram[ram_idx] <= ad_i;
    end
  end

  // ----------------------------------------------------------
  // status and enable registers
  // ----------------------------------------------------------
  always @* begin
    nxt_status = status_ff;
    if (host_wr && in_bank1 && addr_ff == `RXC_OFS_STATUS) begin
      nxt_status[5:0] = ad_i[5:0];
    end
    if (state_ff == ST_DONE) begin
      nxt_status[`RXC_ST_RCF] = 1'b1;
    end
    if (wake_event) begin
      nxt_status[`RXC_ST_WKF] = 1'b1;
    end
    if (ks_event) begin
      nxt_status[`RXC_ST_KSF] = 1'b1;
    end
    if ((nxt_status[`RXC_ST_WKF] && enable_ff[`RXC_EN_WK_IRQ]) ||
        (nxt_status[`RXC_ST_KSF] && enable_ff[`RXC_EN_KS_IRQ])) begin
      nxt_status[`RXC_ST_PWR_INACT] = 1'b0;
    end
    nxt_status[`RXC_ST_AUX_VALID] = aux_battery_valid_i;
    nxt_status[`RXC_ST_UIP] = uip_ff;
  end

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_ff <= `RXC_RST_STATUS;
      enable_ff <= `RXC_RST_ENABLE;
      date_alarm_ff <= 8'h00;
    end else begin
      status_ff <= nxt_status;
      if (host_wr && in_bank1 && addr_ff == `RXC_OFS_ENABLE) begin
        enable_ff <= ad_i;
      end
      if (host_wr && in_bank1 && addr_ff == `RXC_OFS_DATE_ALARM) begin
        date_alarm_ff <= ad_i;
      end
    end
  end

  // ----------------------------------------------------------
  // read data path
  // ----------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ad_o <= 8'h00;
      ad_oe_o <= 1'b0;
    end else begin
      ad_oe_o <= host_rd;
      if (!in_bank1 && ram_sel) begin
        ad_o <= user_ram[ram_idx];
      end else if (in_bank1 && addr_ff == `RXC_OFS_STATUS) begin
        ad_o <= status_ff;
      end else if (in_bank1 && addr_ff == `RXC_OFS_ENABLE) begin
        ad_o <= enable_ff;
      end else if (in_bank1 && addr_ff == `RXC_OFS_DATE_ALARM) begin
        ad_o <= date_alarm_ff;
      end else if (in_bank1 && addr_ff == `RXC_OFS_STACK_LO) begin
        ad_o <= stk_p2;
      end else if (in_bank1 && addr_ff == `RXC_OFS_STACK_HI) begin
        ad_o <= stk_p3;
      end else begin
        ad_o <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_n_o <= 1'b1;
      power_on_output_n_o <= 1'b0;
      power_on_oe_o <= 1'b0;
      pwr_hold_ff <= 1'b0;
      square_wave_output_o <= 1'b0;
      xtal_12p5_sel_o <= 1'b0;
      aux_battery_en_o <= 1'b0;
      clear_busy_o <= 1'b0;
    end else begin
      // irq only while supply present; flags pend until cleared
      irq_n_o <= ~(vcc_ok_i & (rc_pend | wk_pend | ks_pend));
      if (vcc_d_ff && !vcc_ok_i) begin
        pwr_hold_ff <= enable_ff[`RXC_EN_PF_SEL];
      end else if (vcc_ok_i) begin
        pwr_hold_ff <= 1'b1;
      end
      // without supply, aux battery must be enabled to drive power pin
      power_on_oe_o <= ~status_ff[`RXC_ST_PWR_INACT] &
        (vcc_ok_i ? 1'b1 :
         (pwr_hold_ff | wk_pend | ks_pend) &
         enable_ff[`RXC_EN_AUX_BAT] & osc_run_i);
      square_wave_output_o <= enable_ff[`RXC_EN_OSC_OUT] & osc_clk_i;
      xtal_12p5_sel_o <= enable_ff[`RXC_EN_XTAL_SEL];
      aux_battery_en_o <= enable_ff[`RXC_EN_AUX_BAT];
      clear_busy_o <= (state_ff != ST_IDLE) | locked;
    end
  end
endmodule // rxc_ext_ctrl

// ===== testbench/rxc_ext_ctrl_chk.sv
`timescale 1ns/1ps
// ------------------------------
// port checks
// ------------------------------
module rxc_chk (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire cs_n_i,
  input wire rd_n_i,
  input wire vcc_ok_i,
  input wire osc_clk_i,
  input wire ram_clear_input_n_i,
  input wire ad_oe_o,
  input wire irq_n_o,
  input wire power_on_output_n_o,
  input wire power_on_oe_o,
  input wire square_wave_output_o,
  input wire clear_busy_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_no_supply;
    !vcc_ok_i ##1 !vcc_ok_i;
  endsequence
  sequence s_clear_run;
    ##[1:3] clear_busy_o ##[1:600] !clear_busy_o;
  endsequence
  chk_read_answer: assert property (ad_oe_o |->
    $past(rd_n_i) == 1'b0 && $past(cs_n_i) == 1'b0)
    else $error("bus driven without read");
  chk_read_release: assert property (rd_n_i |=> !ad_oe_o)
    else $error("bus held after read");
  chk_lockout_quiet: assert property (
    $fell(ram_clear_input_n_i) |=> (!ad_oe_o) [*8])
    else $error("read answered in lockout");
  chk_clear_bounded: assert property (
    $fell(ram_clear_input_n_i) |-> s_clear_run)
    else $error("clear did not run or end");
  chk_irq_no_supply: assert property (s_no_supply |-> irq_n_o)
    else $error("irq low without supply");
  chk_pwr_open_drain: assert property (
    power_on_oe_o |-> !power_on_output_n_o)
    else $error("power pin driven high");
  chk_sqw_gated: assert property (
    square_wave_output_o |-> $past(osc_clk_i))
    else $error("square wave not from oscillator");
  chk_reset_idle: assert property ($rose(rst_n_i) |->
    irq_n_o && !power_on_oe_o && !ad_oe_o)
    else $error("outputs not idle after reset");
endmodule // rxc_chk

bind rxc_ext_ctrl rxc_chk u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .vcc_ok_i(vcc_ok_i),
  .osc_clk_i(osc_clk_i), .ram_clear_input_n_i(ram_clear_input_n_i),
  .ad_oe_o(ad_oe_o), .irq_n_o(irq_n_o),
  .power_on_output_n_o(power_on_output_n_o),
  .power_on_oe_o(power_on_oe_o),
  .square_wave_output_o(square_wave_output_o),
  .clear_busy_o(clear_busy_o));

// ===== testbench/rxc_host.sv
`timescale 1ns/1ps
// ------------------------------
// host on the muxed bus
// ------------------------------
module rxc_host (
  input wire ref_clk_i,
  input wire [7:0] ad_o,
  input wire ad_oe_o,
  output wire [7:0] ad_i,
  output logic ale_i,
  output logic cs_n_i,
  output logic rd_n_i,
  output logic wr_n_i,
  output logic bank_i
);
  logic [7:0] drv;
  assign ad_i = ad_oe_o ? ad_o : drv;
  initial begin
    drv = 8'h00;
    ale_i = 1'h0;
    cs_n_i = 1'h1;
    rd_n_i = 1'h1;
    wr_n_i = 1'h1;
    bank_i = 1'h0;
  end
  task automatic acc(input logic w, input logic b, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic oe);
    @(posedge ref_clk_i);
    bank_i <= b;
    ale_i <= 1'h1;
    drv <= a;
    @(posedge ref_clk_i);
    ale_i <= 1'h0;
    @(posedge ref_clk_i);
    cs_n_i <= 1'h0;
    wr_n_i <= ~w;
    rd_n_i <= w;
    drv <= w ? d : ~a;
    repeat (2) @(posedge ref_clk_i);
    q = ad_o;
    oe = ad_oe_o;
    wr_n_i <= 1'h1;
    rd_n_i <= 1'h1;
    @(posedge ref_clk_i);
    cs_n_i <= 1'h1;
    drv <= ~drv;
    @(posedge ref_clk_i);
  endtask
endmodule // rxc_host

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
// ------------------------------
// bench top
// ------------------------------
module tb_top;
  logic ref_clk_i, rst_n_i, vcc, aux, ups, upe, osc, ram_clear_input_n_n, ks_n;
  logic ale, cs_n, rd_n, wr_n, bank, ad_oe, oe;
  logic irq_n, pwr_n, pwr_oe, square_wave_output, xsel, auxen, busy;
  logic [7:0] ad, ad_o, tm, al, q;
  int mismatches, n_tests, cyc;

  rxc_host u_host (.ref_clk_i(ref_clk_i), .ad_o(ad_o), .ad_oe_o(ad_oe),
    .ad_i(ad), .ale_i(ale), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .bank_i(bank));
  rxc_ext_ctrl #(.UIP_LEAD_CYC(20), .REC_CYC(20), .KSPW_CYC(4)) DUT (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ad_i(ad), .ad_o(ad_o),
    .ad_oe_o(ad_oe), .ale_i(ale), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .bank_select_bit_i(bank), .vcc_ok_i(vcc),
    .aux_battery_valid_i(aux), .update_start_i(ups), .update_end_i(upe),
    .osc_clk_i(osc), .osc_run_i(1'h1), .time_sec_i(tm), .time_min_i(tm),
    .time_hour_i(tm), .time_date_i(tm), .alarm_sec_i(al),
    .alarm_min_i(al), .alarm_hour_i(al), .ram_clear_input_n_i(ram_clear_input_n_n),
    .kickstart_input_n_i(ks_n), .irq_n_o(irq_n),
    .power_on_output_n_o(pwr_n), .power_on_oe_o(pwr_oe),
    .square_wave_output_o(square_wave_output), .xtal_12p5_sel_o(xsel),
    .aux_battery_en_o(auxen), .clear_busy_o(busy));

  initial begin
    ref_clk_i = 1'h0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic wrap_up;
    if (mismatches == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      wrap_up;
    end
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
    u_host.acc(1'h1, b, a, d, q, oe);
  endtask
  task automatic rd(input logic b, input logic [7:0] a, input logic [7:0] e);
    u_host.acc(1'h0, b, a, 8'h00, q, oe);
    cmp({7'h00, oe}, 8'h01);
    cmp(q, e);
  endtask
  task automatic settle;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'h1 && n < 8) begin
      @(posedge ref_clk_i);
      n++;
    end
    while (busy !== 1'h0 && n < 1000) begin
      @(posedge ref_clk_i);
      n++;
    end
    cmp({7'h00, busy}, 8'h00);
  endtask

  initial begin
    rst_n_i = 1'h0;
    vcc = 1'h1;
    aux = 1'h1;
    ups = 1'h0;
    upe = 1'h0;
    osc = 1'h0;
    ram_clear_input_n_n = 1'h1;
    ks_n = 1'h1;
    tm = 8'h00;
    al = 8'h33;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    rd(1'h1, 8'h4a, 8'h88);
    rd(1'h1, 8'h4b, 8'h00);
    wr(1'h1, 8'h4a, 8'hf8);
    rd(1'h1, 8'h4a, 8'hb8);
    wr(1'h1, 8'h4c, 8'hff);
    rd(1'h1, 8'h4b, 8'h00);
    aux <= 1'h0;
    rd(1'h1, 8'h4a, 8'h38);
    aux <= 1'h1;
    wr(1'h1, 8'h4a, 8'h08);
    rd(1'h1, 8'h4e, 8'h4a);
    rd(1'h1, 8'h4f, 8'h4a);
    wr(1'h1, 8'h4b, 8'he0);
    settle;
    cmp({6'h00, xsel, auxen}, 8'h03);
    osc <= 1'h1;
    settle;
    cmp({7'h00, square_wave_output}, 8'h01);
    wr(1'h1, 8'h4b, 8'h80);
    settle;
    cmp({6'h00, xsel, auxen}, 8'h01);
    settle;
    cmp({7'h00, square_wave_output}, 8'h00);
    osc <= 1'h0;
    wr(0, 8'h0e, 8'h00);
    wr(0, 8'h3f, 8'h12);
    wr(1'h1, 8'h4b, 8'h14);
    ram_clear_input_n_n <= 1'h0;
    u_host.acc(1'h0, 1'h1, 8'h4a, 8'h00, q, oe);
    cmp({7'h00, oe}, 8'h00);
    wait_idle;
    ram_clear_input_n_n <= 1'h1;
    settle;
    cmp({7'h00, irq_n}, 8'h00);
    rd(1'h0, 8'h0e, 8'hff);
    rd(1'h0, 8'h3f, 8'hff);
    rd(1'h1, 8'h4b, 8'h14);
    rd(1'h1, 8'h4a, 8'h8c);
    wr(1'h1, 8'h4a, 8'h08);
    settle;
    cmp({7'h00, irq_n}, 8'h01);
    wr(1'h1, 8'h4a, 8'h0c);
    settle;
    cmp({7'h00, irq_n}, 8'h00);
    wr(1'h1, 8'h4a, 8'h08);
    wr(1'h1, 8'h4b, 8'h00);
    wr(1'h0, 8'h20, 8'h5a);
    ram_clear_input_n_n <= 1'h0;
    wait_idle;
    ram_clear_input_n_n <= 1'h1;
    rd(1'h0, 8'h20, 8'h5a);
    rd(1'h1, 8'h4a, 8'h88);
    wr(1'h1, 8'h4b, 8'h01);
    ks_n <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    ks_n <= 1'h1;
    rd(1'h1, 8'h4a, 8'h88);
    ks_n <= 1'h0;
    repeat (6) @(posedge ref_clk_i);
    ks_n <= 1'h1;
    settle;
    cmp({6'h00, irq_n, pwr_oe}, 8'h01);
    rd(1'h1, 8'h4a, 8'h81);
    wr(1'h1, 8'h4a, 8'h00);
    settle;
    cmp({6'h00, irq_n, pwr_oe}, 8'h03);
    wr(1'h1, 8'h4a, 8'h08);
    settle;
    cmp({6'h00, irq_n, pwr_oe}, 8'h02);
    wr(1'h1, 8'h4b, 8'h02);
    wr(1'h1, 8'h49, 8'h33);
    tm <= 8'h33;
    settle;
    cmp({6'h00, irq_n, pwr_oe}, 8'h01);
    rd(1'h1, 8'h4a, 8'h82);
    tm <= 8'h00;
    wr(1'h1, 8'h4a, 8'h00);
    wr(1'h1, 8'h4a, 8'h08);
    ups <= 1'h1;
    @(posedge ref_clk_i);
    ups <= 1'h0;
    repeat (25) @(posedge ref_clk_i);
    rd(1'h1, 8'h4a, 8'hc8);
    upe <= 1'h1;
    @(posedge ref_clk_i);
    upe <= 1'h0;
    rd(1'h1, 8'h4a, 8'h88);
    wr(1'h1, 8'h4b, 8'h80);
    wr(1'h1, 8'h4a, 8'h00);
    vcc <= 1'h0;
    settle;
    cmp({7'h00, pwr_oe}, 8'h00);
    @(posedge ref_clk_i);
    vcc <= 1'h1;
    wr(1'h1, 8'h4b, 8'h88);
    wr(1'h1, 8'h4a, 8'h00);
    vcc <= 1'h0;
    settle;
    cmp({7'h00, pwr_oe}, 8'h01);
    wrap_up;
  end
endmodule // tb_top
